// file: trig_cfg.svh
// register offsets, field positions and reset values for the
// trigger connector block; included by the port module and the testbench
`ifndef TRIG_CFG_SVH
`define TRIG_CFG_SVH

// register byte offsets
`define OFS_CTRL        12'h000
`define OFS_PULSE_LEN   12'h004
`define OFS_SEND        12'h008
`define OFS_STATUS      12'h00C

// control register fields
`define CTRL_DIR_BIT    0
`define CTRL_TYPE_LSB   1
`define CTRL_TYPE_MSB   2
`define CTRL_LEVEL_BIT  3

// operation condition register fields
`define STAT_PULSE_BIT  0
`define STAT_ARMED_BIT  5

// reset values
`define CTRL_RESET      32'h0000_0000
`define PULSE_LEN_RESET 32'h0000_0FA0

`endif

// file: trig_pkg.sv
// types shared by the trigger connector block
// assumes trig_cfg.svh is on the include path
package trig_pkg;

    typedef enum logic [1:0]
    {
        on_acquisition_fire,
        on_armed,
        on_user_defined,
        on_reserved
    } out_type_t;

    typedef enum logic [1:0]
    {
        ph_idle,
        ph_data
    } bus_phase_t;

endpackage

// file: pin_sync.sv
// three-stage synchroniser for a pin input with agreement filter
// assumes the pin is asynchronous to hclk
`timescale 1ns/10ps

module pin_sync
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin,
    output logic      level
);

    typedef struct packed
    {
        logic [2:0] stages;
        logic       level;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    always_comb
    begin
        next_st        = st;
        next_st.stages = {st.stages[1:0], pin};
        // first stage only feeds the second
        if (st.stages[1] == st.stages[2])
        begin
            next_st.level = st.stages[2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign level = st.level;

endmodule

// file: trigger_port_output.sv
// trigger connector logic: one two-way trigger port, AHB-Lite registers
// assumes one 40 MHz hclk, async active-low reset, a single bus master
//
// Operation
// - in input direction the pin goes to acquisition as external trigger.
// - in output direction the pin carries the signal of the output type.
// - on_acquisition_fire type emits a pulse each time acquisition fires while no pulse is running.
// - armed type drives high while the device is ready for a trigger.
// - ready state shows in status bit 5 and low-active on an aux pin.
// - user-defined type pulses only on send, else holds the idle level.
// - user-defined idle level is high for one, low for zero.
// - the user pulse has the polarity opposite to the idle level.
// - the user pulse lasts the programmed pulse length.
// - the send command starts the pulse at once.
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "trig_cfg.svh"

module trigger_port_output
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [11:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic                  acq_fire,
    input  wire logic                  acq_armed,
    input  wire logic                  trig_pin_in,
    output logic                       trig_pin_out,
    output logic                       trig_pin_oe,
    output logic                       ext_trigger,
    output logic                       armed_aux_n,
    output trig_pkg::out_type_t        out_type
);
    import trig_pkg::*;

    // =========================================================
    // state
    // =========================================================
    typedef struct packed
    {
        logic        wr_pend;
        logic [11:0] wr_addr;
        logic [31:0] rdata;
        logic        dir_out;
        out_type_t   otype;
        logic        level;
        logic [31:0] pulse_len;
        logic [31:0] count;
        logic        pulse_on;
        logic        pin_out;
        logic        pin_oe;
        logic        ext_trig;
        logic        armed_n;
    } port_state_t;

    port_state_t st;
    port_state_t next_st;
    logic        pin_level;

    function automatic logic [31:0] read_mux
    (
        input logic [11:0] addr,
        input port_state_t s
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        case (addr)
            `OFS_CTRL:
            begin
                v[`CTRL_DIR_BIT]                  = s.dir_out;
                v[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB] = s.otype;
                v[`CTRL_LEVEL_BIT]                = s.level;
            end
            `OFS_PULSE_LEN:
            begin
                v = s.pulse_len;
            end
            `OFS_STATUS:
            begin
                v[`STAT_PULSE_BIT] = s.pulse_on;
                v[`STAT_ARMED_BIT] = acq_armed;
            end
            default:
            begin
                v = 32'h0000_0000;
            end
        endcase
        return v;
    endfunction

    pin_sync u_pin_sync
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (trig_pin_in),
        .level   (pin_level)
    );

    // =========================================================
    // next state
    // =========================================================
    always_comb
    begin
        logic start;
        logic send;
        start   = 1'b0;
        send    = 1'b0;
        next_st = st;

        // ----- bus slave, zero wait states
        next_st.wr_pend = 1'b0;
        if (st.wr_pend)
        begin
            case (st.wr_addr)
                `OFS_CTRL:
                begin
                    next_st.dir_out = hwdata[`CTRL_DIR_BIT];
                    next_st.otype   =
                        out_type_t'(hwdata[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB]);
                    next_st.level   = hwdata[`CTRL_LEVEL_BIT];
                end
                `OFS_PULSE_LEN:
                begin
                    next_st.pulse_len = hwdata;
                end
                `OFS_SEND:
                begin
                    send = hwdata[0];
                end
                default:
                begin
                end
            endcase
        end
        if (hsel && hready && htrans[1])
        begin
            next_st.wr_pend = hwrite;
            next_st.wr_addr = haddr;
            next_st.rdata   = read_mux(haddr, st);
        end

        // ----- input direction feeds acquisition
        next_st.ext_trig = !st.dir_out && pin_level;

        // ----- pulse timer
        if (st.otype == on_acquisition_fire)
        begin
            start = acq_fire;
        end
        else if (st.otype == on_user_defined)
        begin
            start = send;
        end
        if (st.pulse_on)
        begin
            // a new start during the pulse is dropped
            if (st.count <= 32'h0000_0001)
            begin
                next_st.pulse_on = 1'b0;
            end
            next_st.count = st.count - 32'h0000_0001;
        end
        else if (start && st.pulse_len != 32'h0000_0000)
        begin
            next_st.pulse_on = 1'b1;
            next_st.count    = st.pulse_len;
        end
        if (st.otype == on_armed || st.otype == on_reserved)
        begin
            next_st.pulse_on = 1'b0;
        end

        // ----- pin drive
        next_st.pin_oe = st.dir_out;
        case (st.otype)
            on_acquisition_fire:
            begin
                next_st.pin_out = next_st.pulse_on;
            end
            on_armed:
            begin
                next_st.pin_out = acq_armed;
            end
            on_user_defined:
            begin
                // idle level, inverted while pulsing
                next_st.pin_out = st.level ^ next_st.pulse_on;
            end
            default:
            begin
                next_st.pin_out = 1'b0;
            end
        endcase
        if (!st.dir_out)
        begin
            next_st.pin_out = 1'b0;
        end
        next_st.armed_n = !acq_armed;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st           <= '0;
            st.otype     <= on_acquisition_fire;
            st.pulse_len <= `PULSE_LEN_RESET;
            st.armed_n   <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // =========================================================
    // outputs from flip-flops, bus ready and response tied to constants
    // =========================================================
    assign hrdata       = st.rdata;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign trig_pin_out = st.pin_out;
    assign trig_pin_oe  = st.pin_oe;
    assign ext_trigger  = st.ext_trig;
    assign armed_aux_n  = st.armed_n;
    assign out_type     = st.otype;

endmodule

// file: trig_equipment.sv
// model of the equipment on the far side of the trigger connector
// assumes the testbench decides when it drives the line and with what
`timescale 1ns/10ps

module trig_equipment
(
    input  wire logic hclk,
    input  wire logic drive_en,
    input  wire logic drive_val,
    input  wire logic trig_pin_out,
    input  wire logic trig_pin_oe,
    output logic      pin
);
    logic last = 1'b0;

    // ==========
    // wire level
    // no pull on the line: once released it shows the inverse of the last
    // level, so a stale value cannot pass for a driven one
    always @(posedge hclk)
        last <= pin;
    assign pin = trig_pin_oe ? trig_pin_out : (drive_en ? drive_val : ~last);
endmodule

// file: trigger_port_output_assertions.sv
// checker for the trigger connector block, bound to its top module
// assumes one clock hclk and the async active-low reset hresetn
`timescale 1ns/10ps

module trigger_port_output_chk
(
    input wire logic                hclk,
    input wire logic                hresetn,
    input wire logic                hreadyout,
    input wire logic                hresp,
    input wire logic                acq_fire,
    input wire logic                acq_armed,
    input wire logic                trig_pin_in,
    input wire logic                trig_pin_out,
    input wire logic                trig_pin_oe,
    input wire logic                ext_trigger,
    input wire logic                armed_aux_n,
    input wire trig_pkg::out_type_t out_type
);
    import trig_pkg::*;
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ==========
    // pin relations
    a_zero_wait:
        assert property (hreadyout && !hresp)
        else $error("bus wait or error seen");
    a_aux_follow:
        assert property (1'b1 |=> armed_aux_n != $past(acq_armed))
        else $error("aux armed pin wrong");
    a_armed_follow:
        assert property (trig_pin_oe && out_type == on_armed
            && $past(out_type) == on_armed |-> trig_pin_out == $past(acq_armed))
        else $error("armed output wrong");
    a_fire_cause:
        assert property (trig_pin_oe && out_type == on_acquisition_fire
            && $past(out_type) == out_type && $rose(trig_pin_out)
            |-> $past(acq_fire))
        else $error("pulse without acquisition fire");
    a_fire_start:
        assert property (trig_pin_oe && out_type == on_acquisition_fire
            && acq_fire && !trig_pin_out |=> trig_pin_out)
        else $error("acquisition fire not sent");
    // the synchroniser needs several cycles, so only a steady pin is judged
    a_input_follow:
        assert property ((!trig_pin_oe && $stable(trig_pin_in))[*6]
            |-> ext_trigger == trig_pin_in)
        else $error("external trigger not following pin");
    a_oe_quiet:
        assert property (!trig_pin_oe |-> !trig_pin_out)
        else $error("pin value while not driving");
    a_reserved_low:
        assert property (trig_pin_oe && out_type == on_reserved
            && $past(out_type) == on_reserved |-> !trig_pin_out)
        else $error("unused type drives high");
    c_user: cover property (out_type == on_user_defined && $fell(trig_pin_out));
    c_armed: cover property (out_type == on_armed && $rose(trig_pin_out));
    c_input: cover property (!trig_pin_oe && $rose(ext_trigger));
endmodule

bind trigger_port_output trigger_port_output_chk u_chk (.hclk, .hresetn,
    .hreadyout, .hresp, .acq_fire, .acq_armed, .trig_pin_in, .trig_pin_out,
    .trig_pin_oe, .ext_trigger, .armed_aux_n, .out_type);

// file: trigger_port_output_tb.sv
// self-checking testbench for the trigger connector block
// assumes the design, its package, cfg header, checker and equipment model
`timescale 1ns/10ps
`include "trig_cfg.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    n_mismatch++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end

module trigger_port_output_tb;
    import trig_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        acq_fire = 1'b0;
    logic        acq_armed = 1'b0;
    logic        drive_en = 1'b0;
    logic        drive_val = 1'b0;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, pin, trig_pin_out, trig_pin_oe;
    logic        ext_trigger, armed_aux_n;
    out_type_t   out_type;
    int          n_mismatch = 0, samples_checked = 0, cycles = 0, plen;
    logic [11:0] ra[5] = '{`OFS_CTRL, `OFS_PULSE_LEN, `OFS_SEND, `OFS_STATUS,
                           12'h010};
    logic [31:0] rv[5] = '{`CTRL_RESET, `PULSE_LEN_RESET, 32'h0000_0000,
                           32'h0000_0000, 32'h0000_0000};

    always #12.5 hclk = ~hclk;

    trigger_port_output u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .acq_fire, .acq_armed, .trig_pin_in(pin), .trig_pin_out,
        .trig_pin_oe, .ext_trigger, .armed_aux_n, .out_type);
    trig_equipment u_eq (.hclk, .drive_en, .drive_val, .trig_pin_out,
        .trig_pin_oe, .pin);

    // ==========
    // tasks
    task finish_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // from the edge that took the cause: pin at lvl for len cycles;
    // again repeats the send mid-pulse, which must not stretch it
    task pulse_chk(input logic lvl, input int len, input logic again);
        int n;
        @(posedge hclk);
        #1;
        `CHK(trig_pin_out, lvl)
        // the first edge of the pulse is already behind us, and the resend
        // in the middle of the pulse uses up two more edges
        n = again ? 3 : 1;
        if (again)
            bus(1'b1, `OFS_SEND, 32'h0000_0001);
        #1;
        while (trig_pin_out === lvl && n < 200)
        begin
            @(posedge hclk);
            #1;
            n++;
        end
        `CHK(n, len)
    endtask

    always @(posedge hclk)
    begin
        cycles++;
        if (cycles > 5000)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    // ==========
    // main sequence
    initial
    begin
        void'($urandom(32'hb6fb_a5fe));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        `CHK(trig_pin_oe, 1'b0)
        `CHK(armed_aux_n, 1'b1)
        bus(1'b1, 12'h010, 32'hffff_ffff);
        foreach (ra[i])
        begin
            bus(1'b0, ra[i], 32'h0000_0000);
            `CHK(rd, rv[i])
        end
        drive_en <= 1'b1;
        repeat (6)
        begin
            drive_val <= 1'($urandom);
            repeat (8) @(posedge hclk);
            #1;
            `CHK(ext_trigger, drive_val)
        end
        drive_en <= 1'b0;
        plen = 4 + $urandom % 16;
        bus(1'b1, `OFS_PULSE_LEN, 32'(plen));
        bus(1'b1, `OFS_CTRL, 32'h0000_0001);
        repeat (3)
        begin
            acq_fire <= 1'b1;
            @(posedge hclk);
            acq_fire <= 1'b0;
            pulse_chk(1'b1, plen, 1'b0);
        end
        bus(1'b1, `OFS_CTRL, 32'h0000_0003);
        repeat (20)
        begin
            acq_armed <= 1'($urandom);
            @(posedge hclk);
        end
        acq_armed <= 1'b1;
        repeat (2) @(posedge hclk);
        #1;
        `CHK(trig_pin_out, 1'b1)
        `CHK(armed_aux_n, 1'b0)
        bus(1'b0, `OFS_STATUS, 32'h0000_0000);
        `CHK(rd[`STAT_ARMED_BIT], 1'b1)
        acq_armed <= 1'b0;
        for (int lvl = 0; lvl < 2; lvl++)
        begin
            bus(1'b1, `OFS_CTRL, 32'h0000_0005 | 32'(lvl << 3));
            acq_fire <= 1'b1;
            @(posedge hclk);
            acq_fire <= 1'b0;
            repeat (3) @(posedge hclk);
            #1;
            `CHK(trig_pin_out, lvl[0])
            bus(1'b1, `OFS_SEND, 32'h0000_0001);
            pulse_chk(~lvl[0], plen, lvl[0]);
        end
        bus(1'b1, `OFS_CTRL, 32'h0000_0007);
        repeat (2) @(posedge hclk);
        #1;
        `CHK(trig_pin_out, 1'b0)
        `CHK(trig_pin_oe, 1'b1)
        `CHK(out_type, on_reserved)
        finish_test();
    end
endmodule
